// [pkg/scratchpad_pkg.sv]
package scratchpad_pkg;
  // memory function codes
  localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
  localparam logic [7:0] CMD_READ_SP = 8'hAA;
  localparam logic [7:0] CMD_COPY_SP = 8'h55;
  // protection codes and register page addresses
  localparam logic [7:0] PROT_WP = 8'h55;
  localparam logic [7:0] PROT_EPROM = 8'hAA;
  localparam logic [15:0] PROT_BASE = 16'h0080;
  localparam logic [15:0] COPY_PROT_ADDR = 16'h0084;
  localparam logic [15:0] FACTORY_ADDR = 16'h0085;
  localparam logic [15:0] USER_LAST_ADDR = 16'h0087;
  localparam int MEM_BYTES_DEF = 144;
  // end offset and status field positions
  localparam int ES_AA_BIT = 7;
  localparam int ES_PF_BIT = 5;
  localparam logic [2:0] SP_LAST = 3'h7;
  localparam int HDR_BYTES = 3;
  localparam logic [4:0] CRC_BITS = 5'h10;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // values after reset
  localparam logic PF_RST = 1'b1;
  localparam logic AA_RST = 1'b0;
  localparam logic SPEED_RST = 1'b0;
  localparam logic [7:0] MEM_RST = 8'hFF;
  localparam logic [15:0] CRC_RST = 16'h0000;
  // link pacing of the master, index of the last one-cycle phase in each bit slot
  localparam logic [1:0] TX_LAST_PH = 2'h1;
  localparam logic [1:0] RX_LAST_PH = 2'h2;

  // one bit into the reflected crc-16 generator
  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic b);
    crc16_step = (crc[0] ^ b) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
  endfunction
endpackage

// [pkg/owd_if.sv]
`timescale 1ns/100ps
`default_nettype none
// bit-slot link between master and scratchpad device
interface owd_if;
  logic frame;
  logic wr_stb;
  logic wr_bit;
  logic rd_stb;
  logic rd_bit;
  logic od_set;
  logic speed_sel;
  modport device(input frame, wr_stb, wr_bit, rd_stb, od_set, output rd_bit, speed_sel);
  modport master(output frame, wr_stb, wr_bit, rd_stb, od_set, input rd_bit, speed_sel);
endinterface
`default_nettype wire

// [verilog/scratchpad_device.sv]
// Operation
// - end offset loads start, counts bytes
// - partial flag set when data invalid
// - master starts at zero, sends eight
// - status bits 3, 4, 6 read zero
// - copy sets done flag, write clears
// - status register read-only to master
// - target address in low, high bytes
// - nonzero low address bits block copy
// - readback sends low, high, status first
// - unknown command leaves flags untouched
// - copy authorised by echoing three registers
// - standard speed unless overdrive selected
// - write is 0Fh, address low first
// - store from start offset, drop fragments
// - accept bad writes, block later copy
// - crc over command, address, data
// - at end offset 7, inverted crc
// - write-protected target loads memory contents
// - eprom mode loads and of both
// - serves data pages and register page
// - 55h protects, AAh eprom, else open
// - all bytes least significant bit first
`timescale 1ns/100ps
`default_nettype none
module scratchpad_device import scratchpad_pkg::*; #(
  parameter int MEM_BYTES = MEM_BYTES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  owd_if.device link,
  output logic [7:0] es_o,
  output logic [15:0] target_o,
  output logic speed_select_o
);
  typedef enum logic [2:0] {
    ST_CMD = 3'b000, ST_TA1 = 3'b001, ST_TA2 = 3'b010, ST_WDATA = 3'b011,
    ST_RSP = 3'b100, ST_AUTH = 3'b101, ST_COPIED = 3'b110, ST_IGNORE = 3'b111
  } dev_state_t;

  dev_state_t state_ff;
  logic [2:0] bcnt_ff;
  logic [7:0] rsh_ff;
  logic [15:0] crc_ff;
  logic [7:0] target_address_low;
  logic [7:0] target_address_high;
  logic [2:0] e_ff;
  logic partial_data_flag;
  logic copy_done_flag;
  logic first_ff;
  logic done_ff;
  logic [7:0] sp_ff [8];
  logic [7:0] mem_ff [MEM_BYTES];
  logic [3:0] rsp_idx_ff;
  logic [2:0] ocnt_ff;
  logic [4:0] post_ff;
  logic [1:0] auth_cnt_ff;
  logic auth_ok_ff;
  logic rd_bit_ff;
  logic alt_ff;
  logic speed_ff;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] es;
  logic [2:0] widx;
  logic [15:0] tgt;
  logic [7:0] wval;
  logic [7:0] obyte;
  logic obit;
  logic in_bytes;
  logic [3:0] n_bytes;
  logic copy_go;
  logic [7:0] auth_exp;

  function automatic logic [7:0] mem_rd(input logic [15:0] a);
    mem_rd = (a < 16'(MEM_BYTES)) ? mem_ff[a[7:0]] : MEM_RST;
  endfunction

  function automatic logic is_lock(input logic [7:0] p);
    is_lock = (p == PROT_WP) || (p == PROT_EPROM);
  endfunction

  // 0 open, 1 write-protected, 2 eprom; register page bytes 80h to 84h lock themselves
  function automatic logic [1:0] mode(input logic [15:0] a);
    logic [7:0] p;
    p = mem_rd(PROT_BASE | {14'h0000, a[6:5]});
    if (a < PROT_BASE)
      mode = (p == PROT_WP) ? 2'd1 : ((p == PROT_EPROM) ? 2'd2 : 2'd0);
    else if (a < FACTORY_ADDR)
      mode = is_lock(mem_rd(a)) ? 2'd1 : 2'd0;
    else if (a == FACTORY_ADDR || a > USER_LAST_ADDR)
      mode = 2'd1;
    else
      mode = (mem_rd(FACTORY_ADDR) == PROT_EPROM) ? 2'd1 : 2'd0;
  endfunction

  // byte assembly, lsb first
  assign byte_done = link.wr_stb && (bcnt_ff == 3'd7);
  assign rx_byte = {link.wr_bit, rsh_ff[7:1]};
  assign es = {copy_done_flag, 1'b0, partial_data_flag, 2'b00, e_ff};
  assign widx = first_ff ? e_ff : e_ff + 3'd1;
  assign tgt = {target_address_high, target_address_low[7:3], widx};

  // value loaded into the scratchpad depends on target protection
  always_comb begin
    case (mode(tgt))
      2'd1: wval = mem_rd(tgt);
      2'd2: wval = rx_byte & mem_rd(tgt);
      default: wval = rx_byte;
    endcase
  end

  // readback byte selection: header then scratchpad from start offset
  assign n_bytes = 4'(HDR_BYTES) + {1'b0, e_ff} - {1'b0, target_address_low[2:0]} + 4'd1;
  assign in_bytes = rsp_idx_ff < n_bytes;
  always_comb begin
    case (rsp_idx_ff)
      4'd0: obyte = target_address_low;
      4'd1: obyte = target_address_high;
      4'd2: obyte = es;
      default: obyte = sp_ff[3'(target_address_low[2:0] + rsp_idx_ff[2:0] - 3'd3)];
    endcase
  end

  // bit returned in a read slot; 1 means the line is left alone
  always_comb begin
    obit = 1'b1;
    case (state_ff)
      ST_WDATA: if (done_ff && post_ff < CRC_BITS) obit = ~crc_ff[post_ff[3:0]];
      ST_RSP: begin
        if (in_bytes)
          obit = obyte[ocnt_ff];
        else if (post_ff < CRC_BITS)
          obit = ~crc_ff[post_ff[3:0]];
      end
      ST_COPIED: obit = alt_ff;
      default: obit = 1'b1;
    endcase
  end

  // copy only with matching pattern, full row, aligned, not copy protected
  always_comb begin
    case (auth_cnt_ff)
      2'd0: auth_exp = target_address_low;
      2'd1: auth_exp = target_address_high;
      default: auth_exp = es;
    endcase
  end
  assign copy_go = (state_ff == ST_AUTH) && byte_done && (auth_cnt_ff == 2'd2) && auth_ok_ff
    && (rx_byte == es) && !partial_data_flag
    && (target_address_low[2:0] == 3'b000)
    && ({target_address_high, target_address_low} < 16'(MEM_BYTES))
    && !(is_lock(mem_rd(COPY_PROT_ADDR))
      && (target_address_high != 8'h00 || target_address_low >= PROT_BASE[7:0]
      || mode({target_address_high, target_address_low}) == 2'd1));

  // command sequencing; frame low returns to command phase
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_CMD;
    end else if (ce_i) begin
      if (!link.frame)
        state_ff <= ST_CMD;
      else if (byte_done || copy_go) begin
        case (state_ff)
          ST_CMD: begin
            case (rx_byte)
              CMD_WRITE_SP: state_ff <= ST_TA1;
              CMD_READ_SP: state_ff <= ST_RSP;
              CMD_COPY_SP: state_ff <= ST_AUTH;
              default: state_ff <= ST_IGNORE;
            endcase
          end
          ST_TA1: state_ff <= ST_TA2;
          ST_TA2: state_ff <= ST_WDATA;
          ST_AUTH: if (copy_go) state_ff <= ST_COPIED;
            else if (auth_cnt_ff == 2'd2) state_ff <= ST_IGNORE;
          default: state_ff <= state_ff;
        endcase
      end
    end
  end

  // bit shifter; a fragment left at frame end is dropped
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcnt_ff <= 3'd0;
      rsh_ff <= 8'h00;
    end else if (ce_i) begin
      if (!link.frame)
        bcnt_ff <= 3'd0;
      else if (link.wr_stb) begin
        bcnt_ff <= bcnt_ff + 3'd1;
        rsh_ff <= rx_byte;
      end
    end
  end

  // crc over bits received in command, address and data phases, and every byte bit sent on readback
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_ff <= CRC_RST;
    end else if (ce_i) begin
      if (!link.frame)
        crc_ff <= CRC_RST;
      else if (link.wr_stb && state_ff <= ST_WDATA)
        crc_ff <= crc16_step(crc_ff, link.wr_bit);
      else if (link.rd_stb && state_ff == ST_RSP && in_bytes)
        crc_ff <= crc16_step(crc_ff, obit);
    end
  end

  // address registers, end offset and flags; only device logic writes them
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      target_address_low <= 8'h00;
      target_address_high <= 8'h00;
      e_ff <= 3'd0;
      partial_data_flag <= PF_RST;
      copy_done_flag <= AA_RST;
      first_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce_i && link.frame) begin
      if (copy_go)
        copy_done_flag <= 1'b1;
      else if (byte_done) begin
        case (state_ff)
          ST_CMD: if (rx_byte == CMD_WRITE_SP) begin
            copy_done_flag <= 1'b0;
            partial_data_flag <= 1'b1;
          end
          ST_TA1: target_address_low <= rx_byte;
          ST_TA2: begin
            target_address_high <= rx_byte;
            e_ff <= target_address_low[2:0];
            first_ff <= 1'b1;
            done_ff <= 1'b0;
          end
          ST_WDATA: if (!done_ff) begin
            e_ff <= widx;
            first_ff <= 1'b0;
            if (widx == SP_LAST) begin
              done_ff <= 1'b1;
              partial_data_flag <= 1'b0;
            end
          end
          default: e_ff <= e_ff;
        endcase
      end
    end
  end

  // scratchpad store
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++) sp_ff[i] <= MEM_RST;
    end else if (ce_i && link.frame && byte_done && state_ff == ST_WDATA && !done_ff) begin
      sp_ff[widx] <= wval;
    end
  end

  // row copy into memory; the model keeps memory in flops
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < MEM_BYTES; i++) mem_ff[i] <= MEM_RST;
    end else if (ce_i && copy_go) begin
      for (int i = 0; i < 8; i++) mem_ff[{target_address_low[7:3], 3'(i)}] <= sp_ff[i];
    end
  end

  // readback counters and authorisation compare
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_idx_ff <= 4'd0;
      ocnt_ff <= 3'd0;
      post_ff <= 5'd0;
      auth_cnt_ff <= 2'd0;
      auth_ok_ff <= 1'b1;
      alt_ff <= 1'b0;
    end else if (ce_i) begin
      if (!link.frame) begin
        rsp_idx_ff <= 4'd0;
        ocnt_ff <= 3'd0;
        post_ff <= 5'd0;
        auth_cnt_ff <= 2'd0;
        auth_ok_ff <= 1'b1;
        alt_ff <= 1'b0;
      end else begin
        if (link.rd_stb) begin
          if (state_ff == ST_RSP && in_bytes) begin
            ocnt_ff <= ocnt_ff + 3'd1;
            if (ocnt_ff == 3'd7) rsp_idx_ff <= rsp_idx_ff + 4'd1;
          end else if (post_ff < CRC_BITS && (state_ff == ST_RSP || done_ff))
            post_ff <= post_ff + 5'd1;
          if (state_ff == ST_COPIED) alt_ff <= ~alt_ff;
        end
        if (byte_done && state_ff == ST_AUTH) begin
          auth_cnt_ff <= auth_cnt_ff + 2'd1;
          auth_ok_ff <= auth_ok_ff && (rx_byte == auth_exp);
        end
      end
    end
  end

  // slot answer stands until the next read slot; outside frames the line floats high
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      rd_bit_ff <= 1'b1;
    else if (ce_i && !link.frame)
      rd_bit_ff <= 1'b1;
    else if (ce_i && link.rd_stb)
      rd_bit_ff <= obit;
  end

  // overdrive only on explicit request
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      speed_ff <= SPEED_RST;
    else if (ce_i && link.od_set)
      speed_ff <= 1'b1;
  end

  assign link.rd_bit = rd_bit_ff;
  assign link.speed_sel = speed_ff;
  assign es_o = es;
  assign target_o = {target_address_high, target_address_low};
  assign speed_select_o = speed_ff;
endmodule // scratchpad_device
`default_nettype wire

// [verilog/scratchpad_master.sv]
`timescale 1ns/100ps
`default_nettype none
module scratchpad_master import scratchpad_pkg::*; #(
  parameter int DW = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic frame_i,
  input wire logic od_set_i,
  input wire logic tx_valid_i,
  input wire logic [DW-1:0] tx_data_i,
  output logic tx_ready_o,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  output logic rx_valid_o,
  output logic [DW-1:0] rx_data_o,
  input wire logic rx_ready_i,
  owd_if.master link
);
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_TX = 2'b01, M_RX = 2'b10} m_state_t;

  m_state_t state_ff;
  logic [1:0] ph_ff;
  logic [$clog2(DW)-1:0] bit_ff;
  logic [DW-1:0] sh_ff;
  logic frame_ff;
  logic wr_stb_ff;
  logic wr_bit_ff;
  logic rd_stb_ff;
  logic od_ff;
  logic [DW-1:0] fifo_ff [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_ff;
  logic [$clog2(DEPTH)-1:0] rp_ff;
  logic [$clog2(DEPTH):0] cnt_ff;
  logic push;
  logic pop;
  logic last_bit;

  // reads start only with room in the buffer, so a stalled consumer loses nothing
  assign tx_ready_o = frame_ff && state_ff == M_IDLE;
  assign rd_ready_o = tx_ready_o && cnt_ff < ($clog2(DEPTH)+1)'(DEPTH);
  assign last_bit = bit_ff == ($clog2(DW))'(DW - 1);
  assign push = state_ff == M_RX && ph_ff == RX_LAST_PH && last_bit;
  assign pop = rx_valid_o && rx_ready_i;

  // bytes go out in the order the user gives them, lsb first
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= M_IDLE;
      ph_ff <= 2'd0;
      bit_ff <= '0;
      sh_ff <= '0;
    end else if (ce_i) begin
      case (state_ff)
        M_IDLE: begin
          ph_ff <= 2'd0;
          bit_ff <= '0;
          if (tx_valid_i && tx_ready_o) begin
            sh_ff <= tx_data_i;
            state_ff <= M_TX;
          end else if (rd_valid_i && rd_ready_o)
            state_ff <= M_RX;
        end
        M_TX: begin
          ph_ff <= (ph_ff == TX_LAST_PH) ? 2'd0 : ph_ff + 2'd1;
          if (ph_ff == TX_LAST_PH) begin
            sh_ff <= sh_ff >> 1;
            bit_ff <= bit_ff + 1'b1;
            if (last_bit) state_ff <= M_IDLE;
          end
        end
        M_RX: begin
          ph_ff <= (ph_ff == RX_LAST_PH) ? 2'd0 : ph_ff + 2'd1;
          if (ph_ff == RX_LAST_PH) begin
            sh_ff <= {link.rd_bit, sh_ff[DW-1:1]};
            bit_ff <= bit_ff + 1'b1;
            if (last_bit) state_ff <= M_IDLE;
          end
        end
        default: state_ff <= M_IDLE;
      endcase
    end
  end

  // registered link strobes, one cycle each
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_bit_ff <= 1'b0;
      rd_stb_ff <= 1'b0;
      od_ff <= 1'b0;
    end else if (ce_i) begin
      frame_ff <= frame_i;
      wr_stb_ff <= state_ff == M_TX && ph_ff == 2'd0;
      wr_bit_ff <= sh_ff[0];
      rd_stb_ff <= state_ff == M_RX && ph_ff == 2'd0;
      od_ff <= od_set_i;
    end
  end

  // two-entry receive buffer
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      for (int i = 0; i < DEPTH; i++) fifo_ff[i] <= '0;
    end else if (ce_i) begin
      if (push) begin
        fifo_ff[wp_ff] <= {link.rd_bit, sh_ff[DW-1:1]};
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) rp_ff <= rp_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign rx_valid_o = cnt_ff != '0;
  assign rx_data_o = fifo_ff[rp_ff];
  assign link.frame = frame_ff;
  assign link.wr_stb = wr_stb_ff;
  assign link.wr_bit = wr_bit_ff;
  assign link.rd_stb = rd_stb_ff;
  assign link.od_set = od_ff;
endmodule // scratchpad_master
`default_nettype wire

// [bench/scratchpad_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// slot-level checks on the link joining master and device
module scratchpad_monitor (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic frame_i,
  input wire logic wr_stb_i,
  input wire logic wr_bit_i,
  input wire logic rd_stb_i,
  input wire logic rd_bit_i,
  input wire logic od_set_i,
  input wire logic speed_sel_i
);
  logic od_seen_ff;
  logic [2:0] wr_cnt_ff;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // any overdrive request since reset; only that may lift the speed
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      od_seen_ff <= 1'b0;
    end else if (od_set_i) begin
      od_seen_ff <= 1'b1;
    end
  end

  // write slots modulo one byte, restarted outside frames
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_cnt_ff <= 3'h0;
    end else if (!frame_i) begin
      wr_cnt_ff <= 3'h0;
    end else if (wr_stb_i) begin
      wr_cnt_ff <= wr_cnt_ff + 3'h1;
    end
  end

  a_speed_default: assert property (speed_sel_i |-> od_seen_ff)
    else $error("speed raised without request");
  a_speed_sticky: assert property (speed_sel_i |=> speed_sel_i)
    else $error("speed dropped");
  a_rd_stable: assert property (frame_i && $past(frame_i) && !$past(rd_stb_i) |-> $stable(rd_bit_i))
    else $error("answer bit moved without read slot");
  a_wr_pulse: assert property (wr_stb_i |=> !wr_stb_i)
    else $error("write slot longer than one cycle");
  a_rd_gap: assert property (rd_stb_i |=> !rd_stb_i [*2])
    else $error("read slots too close");
  a_slot_exclusive: assert property (!(wr_stb_i && rd_stb_i))
    else $error("read and write slot together");
  a_slot_framed: assert property ((wr_stb_i || rd_stb_i) |-> frame_i)
    else $error("slot outside frame");
  a_whole_bytes: assert property ($fell(frame_i) |-> wr_cnt_ff == 3'h0)
    else $error("frame closed mid byte");
endmodule // scratchpad_monitor
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench import scratchpad_pkg::*; ();
  logic ref_clk_i, nrst_i, ce_i, frame_i, od_set_i, tx_valid_i, rd_valid_i, rx_ready_i;
  logic tx_ready_o, rd_ready_o, rx_valid_o, speed_select_o;
  logic [7:0] tx_data_i, rx_data_o, es_o, b;
  logic [15:0] target_o, crc;
  logic [7:0] wd [8];
  logic [7:0] rb [11];
  int num_errors = 0;
  int checks_done = 0;

  owd_if link();
  scratchpad_device i_scratchpad_device (.ref_clk_i, .nrst_i, .ce_i, .link(link),
    .es_o, .target_o, .speed_select_o);
  scratchpad_master i_scratchpad_master (.ref_clk_i, .nrst_i, .ce_i, .frame_i,
    .od_set_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .rd_valid_i, .rd_ready_o,
    .rx_valid_o, .rx_data_o, .rx_ready_i, .link(link));
  scratchpad_monitor i_scratchpad_monitor (.ref_clk_i, .nrst_i, .frame_i(link.frame),
    .wr_stb_i(link.wr_stb), .wr_bit_i(link.wr_bit), .rd_stb_i(link.rd_stb),
    .rd_bit_i(link.rd_bit), .od_set_i(link.od_set), .speed_sel_i(link.speed_sel));

  // free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bounded waits: a hang shows as a mismatch, not a stuck run
  task automatic wait_rdy();
    for (int k = 0; k < 200 && tx_ready_o !== 1'b1; k++) tick(1);
    check("tx ready", 16'(tx_ready_o), 16'h0001);
  endtask

  task automatic put(input logic [7:0] d);
    wait_rdy();
    tx_valid_i = 1'b1;
    tx_data_i = d;
    tick(1);
    tx_valid_i = 1'b0;
    crc = crc_byte(crc, d);
  endtask

  task automatic req();
    for (int k = 0; k < 200 && rd_ready_o !== 1'b1; k++) tick(1);
    check("rd ready", 16'(rd_ready_o), 16'h0001);
    rd_valid_i = 1'b1;
    tick(1);
    rd_valid_i = 1'b0;
  endtask

  task automatic pop(output logic [7:0] d);
    for (int k = 0; k < 200 && rx_valid_o !== 1'b1; k++) tick(1);
    check("rx valid", 16'(rx_valid_o), 16'h0001);
    d = rx_data_o;
    rx_ready_i = 1'b1;
    tick(1);
    rx_ready_i = 1'b0;
    // let an edge pass so a following pop never re-raises ready in this step
    tick(1);
  endtask

  task automatic get(output logic [7:0] d);
    req();
    pop(d);
  endtask

  task automatic open();
    frame_i = 1'b1;
    crc = CRC_RST;
    tick(2);
  endtask

  // the last byte must be on the wire before the frame drops
  task automatic close();
    wait_rdy();
    frame_i = 1'b0;
    tick(3);
  endtask

  task automatic wr_sp(input logic [15:0] a, input int n);
    open();
    put(CMD_WRITE_SP);
    put(a[7:0]);
    put(a[15:8]);
    for (int i = 0; i < n; i++) put(wd[i]);
    wait_rdy();
  endtask

  task automatic rd_sp(input int n);
    open();
    put(CMD_READ_SP);
    for (int i = 0; i < n + HDR_BYTES; i++) get(rb[i]);
    close();
  endtask

  task automatic cp_sp(input logic [15:0] a, input logic [7:0] es);
    open();
    put(CMD_COPY_SP);
    put(a[7:0]);
    put(a[15:8]);
    put(es);
    get(b);
    close();
  endtask

  task automatic t_reset();
    check("es", 16'(es_o), {8'h00, AA_RST, 1'b0, PF_RST, 5'h00});
    check("target", target_o, 16'h0000);
    check("speed", 16'(speed_select_o), 16'h0000);
  endtask

  task automatic t_full();
    for (int i = 0; i < 8; i++) wd[i] = 8'hA0 + 8'(i);
    wr_sp(16'h0010, 8);
    check("target", target_o, 16'h0010);
    check("es", 16'(es_o), 16'h0007);
    get(b);
    check("crc lo", 16'(b), {8'h00, ~crc[7:0]});
    get(b);
    check("crc hi", 16'(b), {8'h00, ~crc[15:8]});
    close();
    rd_sp(8);
    check("hdr lo", 16'(rb[0]), 16'h0010);
    check("hdr hi", 16'(rb[1]), 16'h0000);
    check("hdr es", 16'(rb[2]), 16'h0007);
    for (int i = 0; i < 8; i++) check("data", 16'(rb[i + 3]), 16'(wd[i]));
    cp_sp(16'h0010, 8'h07);
    check("alternate", 16'(b), 16'h00AA);
    check("es", 16'(es_o), 16'h0087);
  endtask

  task automatic t_unknown();
    open();
    put(8'h3C);
    put(8'h00);
    close();
    check("es", 16'(es_o), 16'h0087);
  endtask

  // receiver stalls: buffer fills and refuses, then drains intact
  task automatic t_partial();
    wr_sp(16'h0013, 2);
    check("es", 16'(es_o), 16'h0024);
    req();
    req();
    tick(60);
    check("buffer full", 16'(rd_ready_o), 16'h0000);
    pop(b);
    check("no crc", 16'(b), 16'h00FF);
    pop(b);
    check("no crc", 16'(b), 16'h00FF);
    close();
    cp_sp(16'h0013, 8'h24);
    check("blocked", 16'(es_o), 16'h0024);
  endtask

  task automatic t_over();
    wr_sp(16'h0005, 4);
    check("es", 16'(es_o), 16'h0007);
    get(b);
    check("crc lo", 16'(b), {8'h00, ~crc[7:0]});
    close();
    // valid row but start offset not aligned: only the alignment test blocks it
    cp_sp(16'h0005, 8'h07);
    check("blocked", 16'(es_o), 16'h0007);
    check("no copy", 16'(b), 16'h00FF);
  endtask

  task automatic t_protect();
    for (int i = 0; i < 8; i++) wd[i] = 8'h96 ^ 8'(i);
    wr_sp(16'h0020, 8);
    close();
    cp_sp(16'h0020, 8'h07);
    check("es", 16'(es_o), 16'h0087);
    for (int i = 0; i < 8; i++) wd[i] = 8'h00;
    wd[0] = PROT_WP;
    wd[1] = PROT_EPROM;
    wr_sp(PROT_BASE, 8);
    close();
    cp_sp(PROT_BASE, 8'h07);
    check("es", 16'(es_o), 16'h0087);
    for (int i = 0; i < 8; i++) wd[i] = 8'h0F;
    wr_sp(16'h0010, 8);
    close();
    rd_sp(8);
    for (int i = 0; i < 8; i++) check("wprot", 16'(rb[i + 3]), 16'(8'hA0 + 8'(i)));
    wr_sp(16'h0020, 8);
    close();
    rd_sp(8);
    for (int i = 0; i < 8; i++) check("eprom", 16'(rb[i + 3]), 16'(8'h06 ^ 8'(i)));
  endtask

  task automatic t_speed();
    // a request while the clock enable is low must be lost
    ce_i = 1'b0;
    od_set_i = 1'b1;
    tick(1);
    od_set_i = 1'b0;
    tick(4);
    check("frozen", 16'(speed_select_o), 16'h0000);
    ce_i = 1'b1;
    od_set_i = 1'b1;
    tick(1);
    od_set_i = 1'b0;
    tick(4);
    check("speed", 16'(speed_select_o), 16'h0001);
  endtask

  // main sequence
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    frame_i = 1'b0;
    od_set_i = 1'b0;
    tx_valid_i = 1'b0;
    tx_data_i = 8'h00;
    rd_valid_i = 1'b0;
    rx_ready_i = 1'b0;
    crc = CRC_RST;
    tick(12);
    nrst_i = 1'b1;
    tick(2);
    t_reset();
    t_full();
    t_unknown();
    t_partial();
    t_over();
    t_protect();
    t_speed();
    wrap_up();
  end

  // watchdog, several times the expected run
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    num_errors++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
